/* File: src/esf_top.sv */
// Self-test lamp coder, weighted error flags and register slave.
// Assumes a 100 MHz clock, synchronous reset, an Avalon-MM master and
// a self-test engine plus error sources inside the recorder.
//
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
module esf_top #(
  parameter int FLASH_HALF_CYC = esf_pkg::FLASH_HALF_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic        st_valid,
  input  wire logic [3:0]  st_fault,
  input  wire logic [7:0]  err_event,
  output logic             selftest_run,
  output logic             init_start,
  output logic             lamp_alarm,
  output logic             lamp_trigger,
  output logic             lamp_scan,
  output logic             lamp_error,
  output logic             lamp_power,
  output logic             irq
);

  esf_pkg::esf_state_type state_r;
  esf_pkg::esf_state_type state_nxt;
  esf_pkg::esf_fault_type fault_r;
  logic [esf_pkg::ERR_W-1:0] flags_r;
  logic [esf_pkg::ERR_W-1:0] flags_nxt;
  logic [esf_pkg::IRQ_W-1:0] istat_r;
  logic [esf_pkg::IRQ_W-1:0] imask_r;
  logic [esf_pkg::IRQ_W-1:0] iset;
  logic [31:0]  readdata_r;
  logic         waitrequest_r;
  logic         selftest_run_r;
  logic         init_start_r;
  logic         lamp_alarm_r;
  logic         lamp_trigger_r;
  logic         lamp_scan_r;
  logic         lamp_error_r;
  logic         lamp_power_r;
  logic         irq_r;
  logic         flash_r;
  logic         flash_tick;
  logic         rd_take;
  logic         wr_acc;
  logic         qry_take;
  logic         por_cmd;
  logic         clr_cmd;
  logic         fault_known;
  logic         st_take;
  logic [2:0]   code_pat;
  logic [7:0]   clr_arg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, then accept
  assign rd_take  = read && waitrequest_r;
  assign wr_acc   = write && !waitrequest_r && byteenable[0];
  assign qry_take = rd_take && (address == esf_pkg::OFS_ERR_QRY);
  assign clr_arg  = byteenable[1] ?
                    writedata[esf_pkg::CTRL_ARG_LSB +: esf_pkg::CTRL_ARG_W] :
                    esf_pkg::CLR_ARG_ALL;
  assign por_cmd  = wr_acc && (address == esf_pkg::OFS_CTRL) &&
                    writedata[esf_pkg::CTRL_POR_BIT];
  assign clr_cmd  = wr_acc && (address == esf_pkg::OFS_CTRL) &&
                    writedata[esf_pkg::CTRL_CLR_BIT] &&
                    (clr_arg == esf_pkg::CLR_ARG_ALL);

  // Waitrequest drops for the single accept cycle of each request
  always_ff @(posedge clk) begin
    if (rst) begin
      waitrequest_r <= 1'b1;
    end else begin
      waitrequest_r <= !((read || write) && waitrequest_r);
    end
  end

  // Read data latched in the wait cycle, stand at the accept edge
  always_ff @(posedge clk) begin
    if (rst) begin
      readdata_r <= 32'h0000_0000;
    end else if (rd_take) begin
      case (address)
        esf_pkg::OFS_STATE:    readdata_r <= {20'h00000, fault_r, 3'h0, state_r};
        esf_pkg::OFS_ERR_QRY:  readdata_r <= {24'h000000, flags_r};
        esf_pkg::OFS_ERR_PEEK: readdata_r <= {24'h000000, flags_r};
        esf_pkg::OFS_IRQ_STAT: readdata_r <= {29'h00000000, istat_r};
        esf_pkg::OFS_IRQ_MASK: readdata_r <= {29'h00000000, imask_r};
        default:               readdata_r <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unit sequencer
  assign st_take = st_valid && (state_r == esf_pkg::ST_TEST);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      esf_pkg::ST_TEST: begin
        if (st_valid) begin
          if (st_fault == esf_pkg::FLT_NONE) begin
            state_nxt = esf_pkg::ST_INIT;
          end else if (st_fault == esf_pkg::FLT_CONFIG) begin
            state_nxt = esf_pkg::ST_CFG;
          end else begin
            state_nxt = esf_pkg::ST_FAULT;
          end
        end
      end
      esf_pkg::ST_CFG: begin
        if (qry_take) begin
          state_nxt = esf_pkg::ST_INIT;
        end
      end
      esf_pkg::ST_INIT:  state_nxt = esf_pkg::ST_NORM;
      esf_pkg::ST_FAULT: state_nxt = esf_pkg::ST_FAULT;
      esf_pkg::ST_NORM:  state_nxt = esf_pkg::ST_NORM;
      default:           state_nxt = esf_pkg::ST_TEST;
    endcase
    if (por_cmd) begin
      state_nxt = esf_pkg::ST_TEST;
    end
  end

  // State register; reset is power-up, so the test starts there
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= esf_pkg::ST_TEST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Self-test verdict capture
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_r <= esf_pkg::FLT_NONE;
    end else if (st_take) begin
      fault_r <= esf_pkg::esf_fault_type'(st_fault);
    end
  end

  // Test request level and initialization pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      selftest_run_r <= 1'b1;
      init_start_r   <= 1'b0;
    end else begin
      selftest_run_r <= (state_nxt == esf_pkg::ST_TEST);
      init_start_r   <= (state_nxt == esf_pkg::ST_INIT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lamp coding
  esf_flash_div #(
    .HALF_CYC (FLASH_HALF_CYC)
  ) u_flash (
    .clk    (clk),
    .rst    (rst),
    .tick_r (flash_tick)
  );

  // Flash phase
  always_ff @(posedge clk) begin
    if (rst) begin
      flash_r <= 1'b0;
    end else if (flash_tick) begin
      flash_r <= !flash_r;
    end
  end

  // Alarm, trigger, scan code per fault
  always_comb begin
    fault_known = 1'b1;
    case (fault_r)
      esf_pkg::FLT_HW:     code_pat = 3'h5;
      esf_pkg::FLT_NVRAM:  code_pat = 3'h4;
      esf_pkg::FLT_DRAM:   code_pat = 3'h6;
      esf_pkg::FLT_LINK:   code_pat = 3'h7;
      esf_pkg::FLT_CKSUM1: code_pat = 3'h1;
      esf_pkg::FLT_CKSUM2: code_pat = 3'h2;
      esf_pkg::FLT_FW_INV: code_pat = 3'h0;
      default: begin
        code_pat    = 3'h7;
        fault_known = 1'b0;
      end
    endcase
  end

  // Lamp drivers
  always_ff @(posedge clk) begin
    if (rst) begin
      lamp_alarm_r   <= 1'b0;
      lamp_trigger_r <= 1'b0;
      lamp_scan_r    <= 1'b0;
      lamp_error_r   <= 1'b0;
      lamp_power_r   <= 1'b1;
    end else begin
      lamp_power_r <= 1'b1;
      case (state_r)
        esf_pkg::ST_FAULT: begin
          {lamp_alarm_r, lamp_trigger_r, lamp_scan_r} <= code_pat;
          // Unknown verdict: steady error with all lamps, outside the set
          lamp_error_r <= fault_known ? flash_r : 1'b1;
        end
        esf_pkg::ST_CFG: begin
          {lamp_alarm_r, lamp_trigger_r, lamp_scan_r} <= 3'h0;
          lamp_error_r <= 1'b1;
        end
        esf_pkg::ST_INIT, esf_pkg::ST_NORM: begin
          {lamp_alarm_r, lamp_trigger_r, lamp_scan_r} <= 3'h0;
          lamp_error_r <= |flags_r;
        end
        default: begin
          {lamp_alarm_r, lamp_trigger_r, lamp_scan_r} <= 3'h0;
          lamp_error_r <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Weighted error flags: a new event beats a clear in the same cycle
  always_comb begin
    flags_nxt = flags_r;
    if (qry_take || clr_cmd) begin
      flags_nxt = '0;
    end
    flags_nxt = flags_nxt | err_event;
  end

  // Flag store; code reads as the sum of pending weights
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_r <= esf_pkg::ERR_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, write one to clear, set wins
  always_comb begin
    iset = '0;
    iset[esf_pkg::IRQ_PASS_BIT]  = st_take && (st_fault == esf_pkg::FLT_NONE);
    iset[esf_pkg::IRQ_FAULT_BIT] = st_take && (st_fault != esf_pkg::FLT_NONE);
    iset[esf_pkg::IRQ_ERR_BIT]   = |err_event;
  end

  // Status and mask registers
  always_ff @(posedge clk) begin
    if (rst) begin
      istat_r <= '0;
      imask_r <= esf_pkg::IRQ_MASK_RST;
    end else begin
      if (wr_acc && (address == esf_pkg::OFS_IRQ_STAT)) begin
        istat_r <= (istat_r & ~writedata[esf_pkg::IRQ_W-1:0]) | iset;
      end else begin
        istat_r <= istat_r | iset;
      end
      if (wr_acc && (address == esf_pkg::OFS_IRQ_MASK)) begin
        imask_r <= writedata[esf_pkg::IRQ_W-1:0];
      end
    end
  end

  // Level interrupt
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(istat_r & imask_r);
    end
  end

  assign readdata     = readdata_r;
  assign waitrequest  = waitrequest_r;
  assign selftest_run = selftest_run_r;
  assign init_start   = init_start_r;
  assign lamp_alarm   = lamp_alarm_r;
  assign lamp_trigger = lamp_trigger_r;
  assign lamp_scan    = lamp_scan_r;
  assign lamp_error   = lamp_error_r;
  assign lamp_power   = lamp_power_r;
  assign irq          = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_test_at_powerup: assert property ($past(rst) |-> selftest_run_r)
    else $error("self-test not running after reset");
  a_por_cmd_rerun: assert property (por_cmd |=> selftest_run_r ##1 selftest_run_r)
    else $error("power-on command did not rerun self-test");
  a_dram_pattern: assert property ((state_r == esf_pkg::ST_FAULT &&
      fault_r == esf_pkg::FLT_DRAM) |=> {lamp_alarm_r, lamp_trigger_r, lamp_scan_r,
      lamp_power_r} == 4'hd)
    else $error("dynamic memory lamp code wrong");
  a_cksum_pattern: assert property ((state_r == esf_pkg::ST_FAULT &&
      fault_r == esf_pkg::FLT_CKSUM1) |=> {lamp_alarm_r, lamp_trigger_r,
      lamp_scan_r} == 3'h1)
    else $error("first processor checksum lamp code wrong");
  a_fault_flashes: assert property ((state_r == esf_pkg::ST_FAULT && fault_known &&
      flash_tick) ##1 state_r == esf_pkg::ST_FAULT |=> $changed(lamp_error_r))
    else $error("error lamp not flashing on test fault");
  a_unknown_steady: assert property ((state_r == esf_pkg::ST_FAULT && !fault_known)
      |=> lamp_error_r && lamp_alarm_r && lamp_trigger_r && lamp_scan_r)
    else $error("unlisted fault not shown as steady pattern");
  a_cfg_steady: assert property (state_r == esf_pkg::ST_CFG |=> lamp_error_r &&
      lamp_power_r && !lamp_alarm_r && !lamp_trigger_r && !lamp_scan_r)
    else $error("configuration fault lamps wrong");
  a_clean_init: assert property ((st_take && st_fault == esf_pkg::FLT_NONE && !por_cmd)
      |=> init_start_r ##1 !init_start_r)
    else $error("initialization pulse missing after clean test");
  a_query_clears: assert property ((qry_take && err_event == 8'h00) |=>
      flags_r == 8'h00)
    else $error("error query did not clear flags");
  a_event_sets: assert property ((err_event[esf_pkg::ERR_TRIG_OVR]) |=>
      flags_r[esf_pkg::ERR_TRIG_OVR])
    else $error("trigger overrun flag lost");
  a_lamp_follows: assert property ((state_r == esf_pkg::ST_NORM && flags_r != 8'h00)
      |=> lamp_error_r)
    else $error("error lamp dark while flags pending");
  a_bus_answer: assert property ((read || write) && waitrequest_r |=> !waitrequest_r)
    else $error("bus request not answered in one cycle");

endmodule : esf_top

/* File: src/esf_pkg.sv */
// Constants for the error status and fault indicator block.
// Assumes a 100 MHz clock and a 32-bit Avalon-MM register bus.
package esf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [4:0] OFS_CTRL     = 5'h00;
  localparam logic [4:0] OFS_STATE    = 5'h04;
  localparam logic [4:0] OFS_ERR_QRY  = 5'h08;
  localparam logic [4:0] OFS_ERR_PEEK = 5'h0c;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h10;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h14;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int CTRL_POR_BIT   = 0;
  localparam int CTRL_CLR_BIT   = 1;
  localparam int CTRL_ARG_LSB   = 8;
  localparam int CTRL_ARG_W     = 8;
  localparam logic [7:0] CLR_ARG_ALL = 8'h00;

  // State register fields
  localparam int STATE_FLT_LSB  = 8;

  // Interrupt status bits
  localparam int IRQ_PASS_BIT   = 0;
  localparam int IRQ_FAULT_BIT  = 1;
  localparam int IRQ_ERR_BIT    = 2;
  localparam int IRQ_W          = 3;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Error flag weights: bit i carries code 2**i
  localparam int ERR_W          = 8;
  localparam int ERR_SYNTAX     = 0;
  localparam int ERR_OPTION     = 1;
  localparam int ERR_CHAN_CFG   = 2;
  localparam int ERR_CAL        = 3;
  localparam int ERR_TRIG_OVR   = 4;
  localparam int ERR_OPEN_TC    = 5;
  localparam int ERR_TABLE      = 6;
  localparam int ERR_CONFLICT   = 7;
  localparam logic [7:0] ERR_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Self-test verdicts
  typedef enum logic [3:0] {
    FLT_NONE   = 4'h0,
    FLT_HW     = 4'h1,
    FLT_NVRAM  = 4'h2,
    FLT_DRAM   = 4'h3,
    FLT_LINK   = 4'h4,
    FLT_CKSUM1 = 4'h5,
    FLT_CKSUM2 = 4'h6,
    FLT_FW_INV = 4'h7,
    FLT_CONFIG = 4'h8
  } esf_fault_type;

  // Unit states, one-hot
  typedef enum logic [4:0] {
    ST_TEST  = 5'h01,
    ST_FAULT = 5'h02,
    ST_CFG   = 5'h04,
    ST_INIT  = 5'h08,
    ST_NORM  = 5'h10
  } esf_state_type;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: error lamp flash half period
  localparam int CLK_HZ        = 100_000_000;
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_HALF_CYC = (CLK_HZ / 1000) * FLASH_HALF_MS;
  localparam int FLASH_CNT_W   = 25;

endpackage : esf_pkg

/* File: src/esf_flash_div.sv */
// Divider making the one-cycle flash tick for the error lamp.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module esf_flash_div #(
  parameter int HALF_CYC = esf_pkg::FLASH_HALF_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick_r
);

  localparam int CNT_W = esf_pkg::FLASH_CNT_W;

  logic [CNT_W-1:0] cnt_r;

  // Count down one half period, pulse, reload
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else if (cnt_r == '0) begin
      cnt_r  <= CNT_W'(HALF_CYC - 1);
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r - 1'b1;
      tick_r <= 1'b0;
    end
  end

endmodule : esf_flash_div

/* File: test/esf_host_model.sv */
// Host-side model: an Avalon-MM master that issues commands and queries.
// Assumes the unit answers every request by dropping waitrequest.
`timescale 1ns/1ps
module esf_host_model (
  input  wire logic        clk,
  output logic [4:0]       address,
  output logic             read,
  output logic             write,
  output logic [31:0]      writedata,
  output logic [3:0]       byteenable,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest,
  output logic             hang
);
  // Idle bus at time zero
  initial begin
    address    = 5'h00;
    read       = 1'b0;
    write      = 1'b0;
    writedata  = 32'h0;
    byteenable = 4'h0;
    hang       = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hold the request until the edge where waitrequest is sampled low
  task wait_ack;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0);
    // The slave answers after one wait cycle; a later answer is flagged
    if (n > 2) hang = 1'b1;
  endtask : wait_ack

  // One write, released only after acceptance
  task bus_write(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    address    <= a;
    writedata  <= d;
    byteenable <= be;
    write      <= 1'b1;
    wait_ack();
    write      <= 1'b0;
  endtask : bus_write

  // One read, data taken at the accepting edge
  task bus_read(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    address <= a;
    read    <= 1'b1;
    wait_ack();
    d = readdata;
    read    <= 1'b0;
  endtask : bus_read

  // Steady configuration fault seen: read and clear the pending code
  task config_query(output logic [31:0] d);
    bus_read(esf_pkg::OFS_ERR_QRY, d);
  endtask : config_query
endmodule : esf_host_model

/* File: test/tb_error_status_and_fault_indicator.sv */
// Self-checking bench for the error status and fault indicator block.
// Assumes the host model drives the register bus; the bench plays the
// self-test engine and the error sources.
`timescale 1ns/1ps
module tb_error_status_and_fault_indicator;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        st_valid = 1'b0;
  logic [3:0]  st_fault = 4'h0;
  logic [7:0]  err_event = 8'h00;
  logic        selftest_run;
  logic        init_start;
  logic        lamp_alarm;
  logic        lamp_trigger;
  logic        lamp_scan;
  logic        lamp_error;
  logic        lamp_power;
  logic        irq;
  logic        hang;
  int          failures = 0;
  int          compares = 0;
  logic [31:0] rd;
  // Expected {alarm,trigger,scan} per verdict 0..7
  localparam logic [23:0] LAMP_TBL = {3'h0, 3'h2, 3'h1, 3'h7, 3'h6, 3'h4, 3'h5, 3'h0};

  always #5 clk = ~clk;

  esf_top #(.FLASH_HALF_CYC(8)) DUT (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .st_valid(st_valid), .st_fault(st_fault),
    .err_event(err_event), .selftest_run(selftest_run), .init_start(init_start),
    .lamp_alarm(lamp_alarm), .lamp_trigger(lamp_trigger), .lamp_scan(lamp_scan),
    .lamp_error(lamp_error), .lamp_power(lamp_power), .irq(irq));

  esf_host_model HOST (.clk(clk), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .hang(hang));

  ////////////////////////////////////////////////////////////////////////////
  // Compare and report
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h got %h", name, exp, got);
    end
  endtask : chk

  task test_done;
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  // Stimulus pulses from the self-test engine and error sources
  task st_pulse(input logic [3:0] v);
    @(posedge clk);
    st_valid <= 1'b1;
    st_fault <= v;
    @(posedge clk);
    st_valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : st_pulse

  task ev_pulse(input logic [7:0] v);
    @(posedge clk);
    err_event <= v;
    @(posedge clk);
    err_event <= 8'h00;
    repeat (2) @(posedge clk);
  endtask : ev_pulse

  // Power-on reset command, then a verdict
  task run_test(input logic [3:0] v);
    HOST.bus_write(esf_pkg::OFS_CTRL, 32'h1, 4'hf);
    repeat (3) @(posedge clk);
    chk("selftest_run", 32'h1, selftest_run);
    st_pulse(v);
  endtask : run_test

  // Count error lamp toggles over 40 cycles
  task flash_count(output int t);
    logic prev;
    t = 0;
    prev = lamp_error;
    repeat (40) begin
      @(posedge clk);
      if (lamp_error !== prev) t++;
      prev = lamp_error;
    end
  endtask : flash_count

  ////////////////////////////////////////////////////////////////////////////
  // Every fault verdict except the configuration one, and an unknown one
  task t_faults;
    int t;
    for (int v = 1; v < 8; v++) begin
      run_test(v[3:0]);
      chk("abc_lamps", LAMP_TBL[v*3 +: 3], {lamp_alarm, lamp_trigger, lamp_scan});
      chk("power_lamp", 32'h1, lamp_power);
      flash_count(t);
      chk("flash_toggles", 32'h5, t);
    end
    run_test(4'h9);
    flash_count(t);
    chk("unknown_lamps", 32'h1f, {lamp_alarm, lamp_trigger, lamp_scan, lamp_error,
      lamp_power});
    chk("unknown_steady", 32'h0, t);
  endtask : t_faults

  // Firmware codes apart: scan only, trigger only, none
  task t_firmware;
    run_test(4'h5);
    chk("cksum1_lamps", 32'h1, {lamp_alarm, lamp_trigger, lamp_scan});
    run_test(4'h6);
    chk("cksum2_lamps", 32'h2, {lamp_alarm, lamp_trigger, lamp_scan});
    run_test(4'h7);
    chk("fw_inv_lamps", 32'h0, {lamp_alarm, lamp_trigger, lamp_scan});
  endtask : t_firmware

  // Configuration fault and the host's query
  task t_config;
    int t;
    run_test(4'h8);
    flash_count(t);
    chk("cfg_lamps", 32'h03, {lamp_alarm, lamp_trigger, lamp_scan, lamp_error,
      lamp_power});
    chk("cfg_steady", 32'h0, t);
    HOST.bus_read(esf_pkg::OFS_STATE, rd);
    chk("cfg_state", 32'h04, rd[4:0]);
    HOST.config_query(rd);
    chk("cfg_code", 32'h0, rd);
    repeat (4) @(posedge clk);
    HOST.bus_read(esf_pkg::OFS_STATE, rd);
    chk("cfg_exit", 32'h10, rd[4:0]);
  endtask : t_config

  // Clean self-test gives exactly one init pulse
  task t_pass;
    int n;
    HOST.bus_write(esf_pkg::OFS_CTRL, 32'h1, 4'hf);
    repeat (3) @(posedge clk);
    @(posedge clk);
    st_valid <= 1'b1;
    st_fault <= 4'h0;
    @(posedge clk);
    st_valid <= 1'b0;
    n = 0;
    repeat (6) begin
      @(posedge clk);
      if (init_start === 1'b1) n++;
    end
    chk("init_pulses", 32'h1, n);
    chk("selftest_done", 32'h0, selftest_run);
    // Pass from this test, fault from the earlier verdicts
    HOST.bus_read(esf_pkg::OFS_IRQ_STAT, rd);
    chk("irq_test_bits", 32'h3, rd);
  endtask : t_pass

  // Each weight, summing, and both ways of clearing
  task t_errors;
    for (int i = 0; i < 8; i++) begin
      ev_pulse(8'h01 << i);
      HOST.bus_read(esf_pkg::OFS_ERR_QRY, rd);
      chk("err_code", 32'h1 << i, rd);
      HOST.bus_read(esf_pkg::OFS_ERR_QRY, rd);
      chk("err_cleared", 32'h0, rd);
    end
    ev_pulse(8'h85);
    ev_pulse(8'h04);
    HOST.bus_read(esf_pkg::OFS_ERR_PEEK, rd);
    chk("err_sum", 32'h85, rd);
    chk("err_lamp_on", 32'h1, lamp_error);
    HOST.bus_write(esf_pkg::OFS_CTRL, 32'h2, 4'he);
    HOST.bus_write(esf_pkg::OFS_CTRL, 32'h0102, 4'hf);
    HOST.bus_read(esf_pkg::OFS_ERR_PEEK, rd);
    chk("err_kept", 32'h85, rd);
    chk("err_lamp_held", 32'h1, lamp_error);
    HOST.bus_write(esf_pkg::OFS_CTRL, 32'h2, 4'hf);
    repeat (3) @(posedge clk);
    HOST.bus_read(esf_pkg::OFS_ERR_PEEK, rd);
    chk("err_clr_cmd", 32'h0, rd);
    chk("err_lamp_off", 32'h0, lamp_error);
  endtask : t_errors

  // Interrupt raise, mask, clear
  task t_irq;
    HOST.bus_write(esf_pkg::OFS_IRQ_MASK, 32'h4, 4'hf);
    HOST.bus_write(esf_pkg::OFS_IRQ_STAT, 32'h7, 4'hf);
    repeat (2) @(posedge clk);
    chk("irq_idle", 32'h0, irq);
    ev_pulse(8'h10);
    chk("irq_set", 32'h1, irq);
    HOST.bus_read(esf_pkg::OFS_IRQ_STAT, rd);
    chk("irq_stat", 32'h4, rd);
    HOST.bus_write(esf_pkg::OFS_IRQ_MASK, 32'h0, 4'hf);
    repeat (2) @(posedge clk);
    chk("irq_masked", 32'h0, irq);
    HOST.bus_write(esf_pkg::OFS_IRQ_MASK, 32'h4, 4'hf);
    HOST.bus_write(esf_pkg::OFS_IRQ_STAT, 32'h4, 4'hf);
    repeat (2) @(posedge clk);
    chk("irq_cleared", 32'h0, irq);
    HOST.bus_read(esf_pkg::OFS_IRQ_MASK, rd);
    chk("irq_mask_rd", 32'h4, rd);
    HOST.bus_read(esf_pkg::OFS_ERR_QRY, rd);
    chk("irq_err_code", 32'h10, rd);
  endtask : t_irq

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    #500000;
    failures++;
    test_done();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("reset_lamps", 32'h01, {lamp_alarm, lamp_trigger, lamp_scan, lamp_error, lamp_power});
    chk("reset_run", 32'h1, selftest_run);
    chk("reset_irq", 32'h0, irq);
    HOST.bus_read(esf_pkg::OFS_IRQ_MASK, rd);
    chk("mask_reset", 32'h0, rd);
    HOST.bus_read(5'h18, rd);
    chk("unmapped", 32'h0, rd);
    t_faults();
    t_firmware();
    t_config();
    t_pass();
    t_errors();
    t_irq();
    chk("bus_hang", 32'h0, hang);
    test_done();
  end
endmodule : tb_error_status_and_fault_indicator
